// [logic/ebu_ext_bus_unit.sv]
// External bus unit: runs CPU accesses on the external multiplexed or
// demultiplexed bus, with windows, chip selects, ready and hold arbitration.
// Assumes a CPU request held stable until done and synchronous pin inputs.
`timescale 1ns/1ns
`include "ebu_map.svh"
// Functional notes
// RULE1: Single chip or four external modes: 8/16 data, muxed or demuxed.
// RULE2: Demuxed: address on address port, data on shared port or low byte.
// RULE3: Muxed: address first on shared port, then data on same lines.
// RULE4: Wait states, tristate time, latch strobe length, rw delay programmable; the rw_delay bit has no effect on the strobes here.
// RULE5: Four address windows each with own bus configuration.
// RULE6: Window 4 overrides 3, window 2 overrides 1 on overlap.
// RULE7: Addresses outside all windows use the default configuration.
// RULE8: Five active-low chip selects, one per window plus default.
// RULE9: Unlatched select bit makes chip selects decode directly from address.
// RULE10: Ready handshake lets slow memories stretch an access.
// RULE11: Arbitration enable hands request and hold pins to the controller.
// RULE12: After reset master role, hold acknowledge driven out.
// RULE13: Direction bit 7 set selects slave role, acknowledge becomes input.
// RULE14: 1M, 256K, 64K spaces drive four, two or no segment lines.
// RULE15: Full 16M space drives all eight segment lines.
// RULE16: Illegal bus access sets its flag and raises class B trap.
// RULE17: Ready held high inserts wait states until it goes low.
// RULE18: Address latch strobe lets logic capture muxed addresses.
// RULE19: Write strobe on every write, or low-byte writes in low-byte mode.
// RULE20: Shared pin gives high byte enable or high byte write strobe.
// RULE21: Master finishes access, floats bus, acknowledges hold until released.
// RULE22: Latched chip selects change only at access boundaries.
module ebu_ext_bus_unit
	import ebu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire ebu_request_type cpu_request,
	output logic cpu_done,
	output logic [15:0] cpu_rdata,
	input wire ebu_bus_cfg_type default_bus_config,
	input wire ebu_bus_cfg_type [3:0] window_bus_config,
	input wire ebu_window_sel_type [3:0] window_address_select,
	input wire logic [15:0] system_config_reg,
	input wire logic write_strobe_cfg,
	input wire ebu_space_type space_size,
	input wire logic arbitration_enable,
	input wire logic [7:0] port6_direction_reg,
	output logic [15:0] shared_ad_port_out,
	output logic shared_ad_port_oe,
	input wire logic [15:0] shared_ad_port_in,
	output logic [15:0] demux_address_port,
	output logic demux_address_oe,
	output logic [7:0] segment_address,
	output logic [7:0] segment_address_oe,
	output logic addr_latch_strobe,
	output logic read_strobe_n,
	output logic write_strobe_low,
	output logic high_byte_pin_n,
	output logic strobe_oe,
	output logic [4:0] chip_select_n,
	input wire logic ready_n,
	input wire logic hold_request_n,
	input wire logic hold_ack_in_n,
	output logic hold_acknowledge_n,
	output logic hold_acknowledge_oe,
	output logic bus_request_out_n,
	output logic illegal_bus_flag,
	output logic class_b_trap,
	output logic [7:0] trap_number,
	output logic [23:0] class_b_trap_vector
);
	typedef enum logic [2:0] {
		EBU_IDLE, EBU_ADDR, EBU_TRI, EBU_DATA, EBU_FINISH, EBU_HOLD,
		EBU_WAIT_GRANT
	} ebu_state_type;

	// Window hit: compare upper address bits above the window size
	function automatic logic window_hit(input ebu_window_sel_type sel,
			input logic [23:0] addr);
		logic [23:0] mask;
		logic [23:0] base;
		mask = 24'hFFFFFF << (5'd12 + {1'b0, sel.size});
		base = {sel.base, 12'h000};
		window_hit = ((addr & mask) == (base & mask));
	endfunction

	// Highest window taking precedence, 0 for the default region
	function automatic logic [2:0] select_region(input logic [23:0] addr,
			input ebu_window_sel_type [3:0] sel,
			input ebu_bus_cfg_type [3:0] cfg);
		logic [3:0] hit;
		hit = 4'h0;
		for (int i = 0; i < `EBU_WINDOWS; i++) begin
			hit[i] = cfg[i].enable && window_hit(sel[i], addr); // RULE5
		end
		if (hit[3]) begin // RULE6
			select_region = 3'h4;
		end else if (hit[2]) begin
			select_region = 3'h3;
		end else if (hit[1]) begin // RULE6
			select_region = 3'h2;
		end else if (hit[0]) begin
			select_region = 3'h1;
		end else begin
			select_region = `EBU_DEFAULT_CS; // RULE7
		end
	endfunction

	ebu_state_type state, next_state;
	ebu_bus_cfg_type cfg, next_cfg;
	logic [2:0] region, next_region;
	logic [3:0] count, next_count;
	logic [4:0] cs_latched, next_cs_latched;
	logic hold_active, next_hold_active;
	logic slave_mode;
	logic [2:0] live_region;
	ebu_bus_cfg_type live_cfg;
	logic [4:0] live_cs;
	logic is_mux, is_d8, nx_mux, nx_d8;
	logic next_done, next_illegal, next_ale, next_rd_n, next_wr_n;
	logic next_hb_n, next_ad_oe, next_float, next_bus_request_out_n, next_hold_acknowledge_n;
	logic [15:0] next_rdata, next_ad_out;
	logic [4:0] next_cs_n;
	logic [7:0] next_seg_oe;

	assign slave_mode = port6_direction_reg[`EBU_DIR_SLAVE_BIT]; // RULE13
	assign live_region = select_region(cpu_request.address,
		window_address_select, window_bus_config);
	assign live_cfg = (live_region == `EBU_DEFAULT_CS) ? default_bus_config :
		window_bus_config[live_region - 3'h1];
	assign is_mux = (cfg.mode == EBU_D8_MUX) || (cfg.mode == EBU_D16_MUX);
	assign is_d8 = (cfg.mode == EBU_D8_MUX) || (cfg.mode == EBU_D8_DEMUX);
	assign nx_mux = (next_cfg.mode == EBU_D8_MUX) ||
		(next_cfg.mode == EBU_D16_MUX);
	assign nx_d8 = (next_cfg.mode == EBU_D8_MUX) ||
		(next_cfg.mode == EBU_D8_DEMUX);
	assign live_cs = 5'h01 << live_region;

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cfg = cfg;
		next_region = region;
		next_count = count;
		next_cs_latched = cs_latched;
		next_hold_active = hold_active;
		next_done = 1'b0;
		next_illegal = 1'b0;
		next_rdata = cpu_rdata;
		unique case (state)
			EBU_IDLE: begin
				if (arbitration_enable && !slave_mode &&
						!hold_request_n) begin
					next_state = EBU_HOLD; // RULE11
					next_hold_active = 1'b1;
				end else if (cpu_request.valid) begin
					if (live_cfg.mode == EBU_SINGLE_CHIP) begin
						next_illegal = 1'b1; // RULE16
						next_done = 1'b1;
						next_state = EBU_FINISH;
					end else if (arbitration_enable && slave_mode &&
							hold_ack_in_n) begin
						next_state = EBU_WAIT_GRANT; // RULE13
					end else begin
						next_cfg = live_cfg; // RULE1
						next_region = live_region;
						next_cs_latched = live_cs; // RULE22
						next_count = live_cfg.long_ale ? 4'h1 : 4'h0; // RULE4
						next_state = EBU_ADDR;
					end
				end
			end
			EBU_WAIT_GRANT: begin
				if (!hold_ack_in_n) begin
					next_state = EBU_IDLE;
				end
			end
			EBU_ADDR: begin
				if (count != 4'h0) begin
					next_count = count - 4'h1;
				end else begin
					next_count = cfg.wait_states; // RULE4
					next_state = (is_mux && !cpu_request.write &&
						cfg.tristate_wait) ? EBU_TRI : EBU_DATA;
				end
			end
			EBU_TRI: begin
				next_state = EBU_DATA; // RULE4
			end
			EBU_DATA: begin
				if (count != 4'h0) begin
					next_count = count - 4'h1;
				end else if (!(cfg.ready_enable && ready_n)) begin
					// RULE10 RULE17
					next_done = 1'b1;
					next_rdata = is_d8 ? {8'h00, shared_ad_port_in[7:0]} :
						shared_ad_port_in; // RULE2
					next_state = EBU_FINISH;
				end
			end
			EBU_FINISH: begin
				next_state = EBU_IDLE; // lets cpu drop its request
			end
			EBU_HOLD: begin
				if (hold_request_n) begin
					next_hold_active = 1'b0; // RULE21
					next_state = EBU_IDLE;
				end
			end
			default: begin
				next_state = EBU_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pin drive, all registered
	// ----------------------------------------------------------------
	// Pins follow next_state so each registered pin shows the phase the
	// sequencer is in; ready and read data are sampled while strobes stand
	always_comb begin
		next_ale = (next_state == EBU_ADDR) && nx_mux; // RULE18
		next_ad_oe = 1'b0;
		next_ad_out = 16'h0000;
		if (next_state == EBU_ADDR && nx_mux) begin
			next_ad_oe = 1'b1; // RULE3
			next_ad_out = cpu_request.address[15:0];
		end else if (next_state == EBU_DATA && cpu_request.write) begin
			next_ad_oe = 1'b1; // RULE2 RULE3
			next_ad_out = cpu_request.wdata;
		end
		next_rd_n = !(next_state == EBU_DATA && !cpu_request.write &&
			!(next_cfg.rw_delay && next_ale)); // RULE4
		next_wr_n = 1'b1;
		next_hb_n = 1'b1;
		if (next_state == EBU_DATA && cpu_request.write) begin
			if (!write_strobe_cfg || nx_d8 || cpu_request.byte_low) begin
				next_wr_n = 1'b0; // RULE19
			end
			next_hb_n = !(cpu_request.byte_high && !nx_d8); // RULE20
		end else if (!write_strobe_cfg && (next_state == EBU_ADDR ||
				next_state == EBU_DATA)) begin
			next_hb_n = !(cpu_request.byte_high && !nx_d8); // RULE20
		end
		next_float = next_hold_active ||
			next_state == EBU_WAIT_GRANT; // RULE21
		if (system_config_reg[`EBU_SYSCFG_UNLATCHED_SELECT_CFG_BIT]) begin
			next_cs_n = (cpu_request.valid && !next_float) ?
				~live_cs : 5'h1F; // RULE9
		end else begin
			next_cs_n = (next_state == EBU_ADDR || next_state == EBU_TRI ||
				next_state == EBU_DATA) ? ~next_cs_latched :
				5'h1F; // RULE8 RULE22
		end
		unique case (space_size)
			EBU_SPACE_64K: next_seg_oe = 8'h00; // RULE14
			EBU_SPACE_256K: next_seg_oe = 8'h03;
			EBU_SPACE_1M: next_seg_oe = 8'h0F;
			EBU_SPACE_16M: next_seg_oe = 8'hFF; // RULE15
		endcase
		if (next_float) begin
			next_seg_oe = 8'h00;
		end
		next_bus_request_out_n = !(arbitration_enable && slave_mode &&
			cpu_request.valid && hold_ack_in_n); // RULE11
		next_hold_acknowledge_n = !(arbitration_enable && !slave_mode &&
			next_hold_active); // RULE12 RULE21
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= EBU_IDLE;
			cfg <= '0;
			region <= 3'h0;
			count <= 4'h0;
			cs_latched <= 5'h00;
			hold_active <= 1'b0;
			cpu_done <= 1'b0;
			cpu_rdata <= 16'h0000;
			shared_ad_port_out <= 16'h0000;
			shared_ad_port_oe <= 1'b0;
			demux_address_port <= 16'h0000;
			demux_address_oe <= 1'b0;
			segment_address <= 8'h00;
			segment_address_oe <= 8'h00;
			addr_latch_strobe <= 1'b0;
			read_strobe_n <= 1'b1;
			write_strobe_low <= 1'b1;
			high_byte_pin_n <= 1'b1;
			strobe_oe <= 1'b1;
			chip_select_n <= 5'h1F;
			hold_acknowledge_n <= 1'b1;
			hold_acknowledge_oe <= 1'b1;
			bus_request_out_n <= 1'b1;
			illegal_bus_flag <= 1'b0;
			class_b_trap <= 1'b0;
			trap_number <= 8'h00;
			class_b_trap_vector <= 24'h000000;
		end else begin
			state <= next_state;
			cfg <= next_cfg;
			region <= next_region;
			count <= next_count;
			cs_latched <= next_cs_latched;
			hold_active <= next_hold_active;
			cpu_done <= next_done;
			cpu_rdata <= next_rdata;
			shared_ad_port_out <= next_ad_out;
			shared_ad_port_oe <= next_ad_oe && !next_float;
			demux_address_port <= cpu_request.address[15:0]; // RULE2
			demux_address_oe <= !nx_mux &&
				next_cfg.mode != EBU_SINGLE_CHIP && !next_float;
			segment_address <= cpu_request.address[23:16];
			segment_address_oe <= next_seg_oe;
			addr_latch_strobe <= next_ale && !next_float;
			read_strobe_n <= next_rd_n;
			write_strobe_low <= next_wr_n;
			high_byte_pin_n <= next_hb_n;
			strobe_oe <= !next_float; // RULE21
			chip_select_n <= next_float ? 5'h1F : next_cs_n;
			hold_acknowledge_n <= next_hold_acknowledge_n;
			hold_acknowledge_oe <= !slave_mode; // RULE12 RULE13
			bus_request_out_n <= next_bus_request_out_n;
			// Sticky until reset: no clear path is given to software here
			illegal_bus_flag <= illegal_bus_flag || next_illegal; // RULE16
			class_b_trap <= next_illegal;
			trap_number <= `EBU_TRAP_NUMBER;
			class_b_trap_vector <= `EBU_TRAP_VECTOR;
		end
	end
endmodule

// [pkg/ebu_map.svh]
// Constants of the external bus unit: field positions, trap codes, window count.
// Assumes inclusion by bare name from the design file.
`ifndef EBU_MAP_SVH
`define EBU_MAP_SVH
`define EBU_WINDOWS 4
`define EBU_SYSCFG_UNLATCHED_SELECT_CFG_BIT 6
`define EBU_DIR_SLAVE_BIT 7
`define EBU_TRAP_NUMBER 8'h0A
`define EBU_TRAP_VECTOR 24'h000028
`define EBU_DEFAULT_CS 3'h0
`endif

// [pkg/ebu_pkg.sv]
// Types of the external bus unit: bus modes, address space, configurations.
// Assumes no surroundings beyond the constants header.
package ebu_pkg;
	// Bus mode field of a configuration register
	typedef enum logic [2:0] {
		EBU_SINGLE_CHIP,
		EBU_D8_DEMUX,
		EBU_D8_MUX,
		EBU_D16_DEMUX,
		EBU_D16_MUX
	} ebu_mode_type;

	typedef enum logic [1:0] {
		EBU_SPACE_64K,
		EBU_SPACE_256K,
		EBU_SPACE_1M,
		EBU_SPACE_16M
	} ebu_space_type;

	// One bus configuration: programmable timing and mode
	typedef struct packed {
		ebu_mode_type mode;
		logic [3:0] wait_states;
		logic tristate_wait;
		logic long_ale;
		logic rw_delay;
		logic ready_enable;
		logic enable;
	} ebu_bus_cfg_type;

	// Window address select: base in 4 KB granules, size as a power of two (window is 4 KB shifted left by size)
	typedef struct packed {
		logic [11:0] base;
		logic [3:0] size;
	} ebu_window_sel_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic byte_high;
		logic byte_low;
		logic [23:0] address;
		logic [15:0] wdata;
	} ebu_request_type;
endpackage

// [tb/ebu_ext_bus_unit_assertions.sv]
// Checker: port relations of the external bus unit.
// Assumes it is bound to the unit; one clock domain.
`timescale 1ns/1ns
module ebu_ext_bus_unit_assertions
	import ebu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire ebu_request_type cpu_request,
	input wire logic cpu_done,
	input wire logic [15:0] system_config_reg,
	input wire logic shared_ad_port_oe,
	input wire logic addr_latch_strobe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_low,
	input wire logic strobe_oe,
	input wire logic [4:0] chip_select_n,
	input wire logic hold_acknowledge_n,
	input wire logic class_b_trap,
	input wire logic [7:0] trap_number,
	input wire logic [23:0] class_b_trap_vector
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ----
	// Relations
	// ----
	a_done_one_cycle: assert property (cpu_done |=> !cpu_done)
		else $error("done held over one cycle");
	a_trap_code: assert property (class_b_trap |-> trap_number == 8'h0A
		&& class_b_trap_vector == 24'h000028) else $error("bad trap code");
	a_single_select: assert property ($onehot0(~chip_select_n))
		else $error("two chip selects low");
	// Latched selects may not glitch inside a read strobe
	a_select_latched: assert property (!system_config_reg[6] &&
		!read_strobe_n && $past(!read_strobe_n) |-> $stable(chip_select_n))
		else $error("select moved mid access");
	a_ale_drives_ad: assert property (addr_latch_strobe |->
		shared_ad_port_oe) else $error("latch strobe with port floated");
	a_write_on_write: assert property (!write_strobe_low |->
		cpu_request.write) else $error("write strobe on a read");
	a_read_on_read: assert property (!read_strobe_n |->
		!cpu_request.write && write_strobe_low) else $error("read on write");
	a_hold_floats: assert property (!hold_acknowledge_n |->
		!strobe_oe && !shared_ad_port_oe) else $error("bus driven in hold");
	c_write: cover property (cpu_done && cpu_request.write);
	c_trap: cover property (class_b_trap);
	c_hold: cover property (!hold_acknowledge_n);
endmodule

// [tb/ebu_memory_model.sv]
// Partner: 256-word external memory with an optional slow ready.
// Assumes registered strobes; word index from address bits 8..1.
`timescale 1ns/1ns
module ebu_memory_model (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic [15:0] shared_ad_port_out,
	input wire logic [15:0] demux_address_port,
	input wire logic demux_address_oe,
	input wire logic addr_latch_strobe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_low,
	output logic [15:0] shared_ad_port_in,
	output logic ready_n
);
	logic [15:0] mem [0:255];
	logic [15:0] last = 16'h0000;
	logic [7:0] idx = 8'h00;
	int stall = 0;
	wire busy = !read_strobe_n || !write_strobe_low;
	// Slow mode holds three strobe cycles off
	assign ready_n = slow && busy && stall < 3;
	// Released bus toggles so stale data never passes
	assign shared_ad_port_in = read_strobe_n ? ~last : mem[idx];
	always @(posedge clk_sys) begin
		last <= shared_ad_port_in;
		stall <= busy ? stall + 1 : 0;
		if (addr_latch_strobe)
			idx <= shared_ad_port_out[8:1];
		else if (demux_address_oe)
			idx <= demux_address_port[8:1];
		if (!write_strobe_low)
			mem[idx] <= shared_ad_port_out;
	end
endmodule

// [tb/ebu_ext_bus_unit_bench.sv]
// Bench: CPU accesses through the bus unit into the memory model.
// Assumes package, unit, model and checker compiled before it.
`timescale 1ns/1ns
module ebu_ext_bus_unit_bench;
	import ebu_pkg::*;
	logic clk_sys, rst_n, cpu_done, write_strobe_cfg, arbitration_enable;
	logic shared_ad_port_oe, demux_address_oe, addr_latch_strobe, strobe_oe;
	logic read_strobe_n, write_strobe_low, high_byte_pin_n, ready_n, slow;
	logic hold_request_n, hold_ack_in_n, hold_acknowledge_n, trap_seen;
	logic hold_acknowledge_oe, bus_request_out_n, illegal_bus_flag;
	logic class_b_trap, ale_seen, hb_seen;
	logic [15:0] cpu_rdata, system_config_reg, shared_ad_port_out, rd;
	logic [15:0] shared_ad_port_in, demux_address_port;
	logic [7:0] port6_direction_reg, segment_address, segment_address_oe;
	logic [7:0] trap_number;
	logic [7:0] seg_tbl [4] = '{8'h00, 8'h03, 8'h0F, 8'hFF};
	logic [4:0] chip_select_n, cs_seen;
	logic [23:0] class_b_trap_vector, exp_v;
	ebu_request_type cpu_request;
	ebu_bus_cfg_type default_bus_config;
	ebu_bus_cfg_type [3:0] window_bus_config, wcfg;
	ebu_window_sel_type [3:0] window_address_select;
	ebu_space_type space_size;
	int failures = 0, checks_done = 0, cyc, c0;
	ebu_ext_bus_unit dut_u (.*);
	ebu_memory_model mem_u (.*);
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Request held until done, dropped in the finish cycle
	task automatic access(input logic w, input logic [23:0] a,
		input logic [15:0] d);
		@(posedge clk_sys);
		cpu_request <= '{1'b1, w, 1'b1, 1'b1, a, d};
		{cyc, cs_seen, ale_seen, trap_seen, hb_seen} = {32'd0, 5'h1F, 3'b001};
		do begin
			@(negedge clk_sys);
			cyc++;
			ale_seen |= addr_latch_strobe;
			trap_seen |= class_b_trap;
			if (!read_strobe_n || !write_strobe_low) begin
				cs_seen = chip_select_n;
				hb_seen = high_byte_pin_n;
			end
		end while (cpu_done !== 1'b1 && cyc < 99);
		rd = cpu_rdata;
		if (cyc >= 99) begin
			check(24'h0, 24'h1);
			conclude();
		end
		@(posedge clk_sys);
		cpu_request.valid <= 1'b0;
	endtask
	task automatic await_ack(input logic v);
		for (int n = 0; hold_acknowledge_n !== v; n++) begin
			if (n == 50) begin
				check(24'h0, 24'h1);
				conclude();
			end
			@(negedge clk_sys);
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		{rst_n, slow, hold_request_n, hold_ack_in_n} = 4'b0011;
		{write_strobe_cfg, arbitration_enable} = 2'b00;
		cpu_request = '0;
		system_config_reg = 16'h0000;
		port6_direction_reg = 8'h00;
		space_size = EBU_SPACE_16M;
		default_bus_config = '{EBU_D16_DEMUX, 4'h0, 1'b0, 1'b0, 1'b0,
			1'b1, 1'b1};
		window_bus_config = '0;
		window_address_select = '0;
		repeat (8) @(posedge clk_sys);
		check(24'(chip_select_n), 24'h1F);
		check(24'(hold_acknowledge_oe), 24'h1);
		rst_n <= 1'b1;
		$display("reset test done");
		for (int m = 1; m <= 4; m++) begin
			default_bus_config.mode <= ebu_mode_type'(m);
			access(1'b1, 24'(64 + 2 * m), 16'hA5C0 + 16'(m));
			access(1'b0, 24'(64 + 2 * m), 16'h0000);
			exp_v = m < 3 ? 24'hC0 + 24'(m) : 24'hA5C0 + 24'(m);
			check(24'(rd), exp_v);
			check(24'(ale_seen), 24'(m % 2 == 0));
			check(24'(hb_seen), 24'(m < 3));
		end
		$display("mode test done");
		default_bus_config.mode <= EBU_D16_DEMUX;
		access(1'b0, 24'h000040, 16'h0000);
		c0 = cyc;
		wcfg = {4{default_bus_config}};
		wcfg[1].wait_states = 4'h5;
		window_bus_config <= wcfg;
		window_address_select <= '{'{12'h002, 4'h0}, '{12'h002, 4'h0},
			'{12'h001, 4'h0}, '{12'h001, 4'h0}};
		{system_config_reg, write_strobe_cfg} <= {16'h0040, 1'b1};
		access(1'b0, 24'h001000, 16'h0000);
		check(24'(cs_seen), 24'h1B);
		check(24'(cyc - c0), 24'h5);
		access(1'b0, 24'h002000, 16'h0000);
		check(24'(cs_seen), 24'h0F);
		access(1'b1, 24'h003000, 16'h1234);
		check(24'(cs_seen), 24'h1E);
		check(24'(hb_seen), 24'h0);
		$display("window test done");
		// Latched selects here so a long strobe checks select stability
		{slow, system_config_reg} <= {1'b1, 16'h0000};
		access(1'b0, 24'h150048, 16'h0000);
		check(24'(cyc - c0), 24'h3);
		check(24'(rd), 24'hA5C4);
		check(24'(segment_address), 24'h15);
		check(24'(demux_address_port), 24'h48);
		slow <= 1'b0;
		$display("ready test done");
		{arbitration_enable, hold_request_n} <= 2'b10;
		await_ack(1'b0);
		check(24'(strobe_oe), 24'h0);
		check(24'(shared_ad_port_oe), 24'h0);
		@(posedge clk_sys);
		hold_request_n <= 1'b1;
		await_ack(1'b1);
		@(posedge clk_sys);
		port6_direction_reg <= 8'h80;
		repeat (2) @(negedge clk_sys);
		check(24'(hold_acknowledge_oe), 24'h0);
		// Slave access waits for the other master's grant
		fork
			access(1'b0, 24'h000048, 16'h0000);
			begin
				repeat (3) @(negedge clk_sys);
				check(24'(bus_request_out_n), 24'h0);
				check(24'(chip_select_n), 24'h1F);
				@(posedge clk_sys);
				hold_ack_in_n <= 1'b0;
			end
		join
		check(24'(rd), 24'hA5C4);
		@(posedge clk_sys);
		{port6_direction_reg, arbitration_enable, hold_ack_in_n} <= 10'h001;
		$display("arbitration test done");
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_sys);
			space_size <= ebu_space_type'(s);
			repeat (2) @(negedge clk_sys);
			check(24'(segment_address_oe), 24'(seg_tbl[s]));
		end
		$display("space test done");
		@(posedge clk_sys);
		default_bus_config.mode <= EBU_SINGLE_CHIP;
		access(1'b0, 24'h000040, 16'h0000);
		check(24'({illegal_bus_flag, trap_seen}), 24'h3);
		check(24'(trap_number), 24'h0A);
		check(class_b_trap_vector, 24'h000028);
		$display("trap test done");
		conclude();
	end
endmodule
bind ebu_ext_bus_unit ebu_ext_bus_unit_assertions chk_u (.*);
